// ### gpio_port_masked_access.sv
// four-port gpio with set/clear, masked byte windows and edge interrupts on axi4-lite
// How it works
// - four independent port blocks a to d, 53 usable pins in total
// - set register drives chosen output bits to 1, clear register drives them to 0
// - chosen port bits are read or written in one bus transfer
// - masked access splits each port into a low byte and a high byte window
// - each window holds 256 words, one address per 8-bit mask pattern
// - low window write: word index is the mask, only masked low bits take data
// - high window write does the same on bits 15 to 8, low byte untouched
// - each pin has its own mask allowing or blocking its interrupt
// - pin interrupts are edge triggered: rising, falling or both selectable
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module gpio_port_masked_access #(
	parameter int NUM_PORTS = gpio_pkg::NUM_PORTS,
	parameter int PORT_W = gpio_pkg::PORT_W
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// axi4-lite write address and data
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [gpio_pkg::ADDR_W-1:0] i_awaddr,
	input wire logic [2:0] i_awprot,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	// axi4-lite write response
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	// axi4-lite read
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [gpio_pkg::ADDR_W-1:0] i_araddr,
	input wire logic [2:0] i_arprot,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	// pads: sampled pin levels in, output values and output enables out
	input wire logic [NUM_PORTS-1:0][PORT_W-1:0] i_pin,
	output logic [NUM_PORTS-1:0][PORT_W-1:0] o_port_output_value,
	output logic [NUM_PORTS-1:0][PORT_W-1:0] o_pin_oe,
	// interrupt
	output logic o_irq
);
	gpio_pkg::port_regs_t regs_q [NUM_PORTS];
	gpio_pkg::ch_state_t wr_state_q;
	gpio_pkg::ch_state_t rd_state_q;
	logic aw_held_q;
	logic w_held_q;
	logic [gpio_pkg::ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic awready_q;
	logic wready_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic prev_valid_q;
	logic irq_q;

	// write channel: address and data are taken in either order, then one write fires
	wire aw_take = i_awvalid & awready_q;
	wire w_take = i_wvalid & wready_q;
	wire wr_go = aw_held_q & w_held_q & (wr_state_q == gpio_pkg::CH_IDLE);
	wire aw_held_d = wr_go ? 1'b0 : (aw_held_q | aw_take);
	wire w_held_d = wr_go ? 1'b0 : (w_held_q | w_take);
	wire gpio_pkg::reg_addr_t wa = gpio_pkg::split_addr(awaddr_q);
	wire wr_ok = gpio_pkg::addr_ok(wa.off);
	wire [15:0] wr_bytes = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire [15:0] wr_val = wdata_q[15:0] & wr_bytes;
	// a window write only updates bytes whose strobe is set
	wire [15:0] wr_win = gpio_pkg::win_mask(wa.off) & wr_bytes;
	wire wr_is_win = (wa.off[11:10] != 2'h0);
	wire wr_is_out = (wa.off == gpio_pkg::OFF_OUT);
	wire wr_is_set = (wa.off == gpio_pkg::OFF_OUT_SET);
	wire wr_is_clr = (wa.off == gpio_pkg::OFF_OUT_CLR);
	wire wr_is_oe = (wa.off == gpio_pkg::OFF_OE);
	wire wr_is_mask = (wa.off == gpio_pkg::OFF_IRQ_MASK);
	wire wr_is_rise = (wa.off == gpio_pkg::OFF_RISE_EN);
	wire wr_is_fall = (wa.off == gpio_pkg::OFF_FALL_EN);
	wire [1:0] wr_resp = wr_ok ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;

	// read channel
	wire rd_go = i_arvalid & arready_q;
	wire gpio_pkg::reg_addr_t ra = gpio_pkg::split_addr(i_araddr);
	wire rd_ok = gpio_pkg::addr_ok(ra.off);
	wire [15:0] rd_win = gpio_pkg::win_mask(ra.off);
	wire [NUM_PORTS-1:0][15:0] rd_val;
	wire [NUM_PORTS-1:0] pend;
	wire rd_is_win = (ra.off[11:10] != 2'h0);
	wire rd_is_pin = (ra.off == gpio_pkg::OFF_PIN);
	wire rd_is_out = (ra.off == gpio_pkg::OFF_OUT) || (ra.off == gpio_pkg::OFF_OUT_SET) ||
		(ra.off == gpio_pkg::OFF_OUT_CLR);
	wire rd_is_oe = (ra.off == gpio_pkg::OFF_OE);
	wire rd_is_mask = (ra.off == gpio_pkg::OFF_IRQ_MASK);
	wire rd_is_rise = (ra.off == gpio_pkg::OFF_RISE_EN);
	wire rd_is_fall = (ra.off == gpio_pkg::OFF_FALL_EN);
	wire rd_is_status = (ra.off == gpio_pkg::OFF_IRQ_STATUS);
	wire [1:0] rd_resp = rd_ok ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
	gpio_pkg::ch_state_t rd_state_d;
	gpio_pkg::ch_state_t wr_state_d;

	// each channel answers one transfer at a time: idle until taken, then answering until the master accepts
	always_comb begin
		rd_state_d = rd_state_q;
		case (rd_state_q)
			gpio_pkg::CH_IDLE: begin
				if (rd_go) begin
					rd_state_d = gpio_pkg::CH_RESP;
				end
			end
			gpio_pkg::CH_RESP: begin
				if (i_rready) begin
					rd_state_d = gpio_pkg::CH_IDLE;
				end
			end
			default: begin
				rd_state_d = gpio_pkg::CH_IDLE;
			end
		endcase
	end

	always_comb begin
		wr_state_d = wr_state_q;
		case (wr_state_q)
			gpio_pkg::CH_IDLE: begin
				if (wr_go) begin
					wr_state_d = gpio_pkg::CH_RESP;
				end
			end
			gpio_pkg::CH_RESP: begin
				if (i_bready) begin
					wr_state_d = gpio_pkg::CH_IDLE;
				end
			end
			default: begin
				wr_state_d = gpio_pkg::CH_IDLE;
			end
		endcase
	end

	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port
			wire [15:0] avail = gpio_pkg::PIN_AVAIL[p];
			wire [15:0] pin = i_pin[p] & avail;
			wire gpio_pkg::port_regs_t r = regs_q[p];
			wire wsel = wr_go & wr_ok & (wa.port == 2'(p));
			wire rsel = rd_go & rd_ok & (ra.port == 2'(p));
			wire [15:0] rise = pin & ~r.pin_prev & r.rise_en;
			wire [15:0] fall = ~pin & r.pin_prev & r.fall_en;
			wire [15:0] evt = prev_valid_q ? (rise | fall) : 16'h0000;
			// a status read clears only the flags it returned
			wire [15:0] clr = (rsel && ra.off == gpio_pkg::OFF_IRQ_STATUS) ? r.status : 16'h0000;
			wire [15:0] out_plain = (r.out & ~wr_bytes) | wr_val;
			wire [15:0] out_set = r.out | wr_val;
			wire [15:0] out_clr = r.out & ~wr_val;
			wire [15:0] out_win = (r.out & ~wr_win) | (wdata_q[15:0] & wr_win);
			logic [15:0] out_d;
			logic [15:0] rd_port;

			// next output data; only a write that hits this port moves it
			always_comb begin
				out_d = r.out;
				if (!wsel) begin
					out_d = r.out;
				end else if (wr_is_win) begin
					out_d = out_win;
				end else if (wr_is_out) begin
					out_d = out_plain;
				end else if (wr_is_set) begin
					out_d = out_set;
				end else if (wr_is_clr) begin
					out_d = out_clr;
				end else begin
					out_d = r.out;
				end
			end

			assign pend[p] = |(r.status & r.irq_mask);

			// register read value; windows show selected pin bits, zero elsewhere
			always_comb begin
				rd_port = 16'h0000;
				if (rd_is_win) begin
					rd_port = pin & rd_win;
				end else if (rd_is_pin) begin
					rd_port = pin;
				end else if (rd_is_out) begin
					rd_port = r.out;
				end else if (rd_is_oe) begin
					rd_port = r.oe;
				end else if (rd_is_mask) begin
					rd_port = r.irq_mask;
				end else if (rd_is_rise) begin
					rd_port = r.rise_en;
				end else if (rd_is_fall) begin
					rd_port = r.fall_en;
				end else if (rd_is_status) begin
					rd_port = r.status;
				end
			end

			assign rd_val[p] = rd_port;

			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					regs_q[p] <= '0;
				end else begin
					regs_q[p].out <= out_d & avail;
					regs_q[p].pin_prev <= pin;
					// new edge wins over a clear in the same cycle
					regs_q[p].status <= ((r.status & ~clr) | evt) & avail;
					if (wsel && wa.off == gpio_pkg::OFF_OE) begin
						regs_q[p].oe <= ((r.oe & ~wr_bytes) | wr_val) & avail;
					end
					if (wsel && wa.off == gpio_pkg::OFF_IRQ_MASK) begin
						regs_q[p].irq_mask <= ((r.irq_mask & ~wr_bytes) | wr_val) & avail;
					end
					if (wsel && wa.off == gpio_pkg::OFF_RISE_EN) begin
						regs_q[p].rise_en <= ((r.rise_en & ~wr_bytes) | wr_val) & avail;
					end
					if (wsel && wa.off == gpio_pkg::OFF_FALL_EN) begin
						regs_q[p].fall_en <= ((r.fall_en & ~wr_bytes) | wr_val) & avail;
					end
				end
			end

			assign o_port_output_value[p] = r.out;
			assign o_pin_oe[p] = r.oe;
		end
	endgenerate

	// port select decodes to one of four 4 KB regions, windows at 0x400 and 0x800
	wire [15:0] rd_sel_val = rd_val[ra.port];

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			wr_state_q <= gpio_pkg::CH_IDLE;
			bresp_q <= gpio_pkg::RESP_OKAY;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			awready_q <= ~aw_held_d;
			wready_q <= ~w_held_d;
			if (aw_take) begin
				awaddr_q <= i_awaddr;
			end
			if (w_take) begin
				wdata_q <= i_wdata;
				wstrb_q <= i_wstrb;
			end
			wr_state_q <= wr_state_d;
			if (wr_go) begin
				bresp_q <= wr_resp;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			rd_state_q <= gpio_pkg::CH_IDLE;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= gpio_pkg::RESP_OKAY;
			prev_valid_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			rd_state_q <= rd_state_d;
			arready_q <= (rd_state_d == gpio_pkg::CH_IDLE);
			rvalid_q <= (rd_state_d == gpio_pkg::CH_RESP);
			if (rd_go) begin
				rdata_q <= {16'h0000, rd_ok ? rd_sel_val : 16'h0000};
				rresp_q <= rd_resp;
			end
			prev_valid_q <= 1'b1;
			irq_q <= |pend;
		end
	end

	assign o_awready = awready_q;
	assign o_wready = wready_q;
	assign o_bvalid = (wr_state_q == gpio_pkg::CH_RESP);
	assign o_bresp = bresp_q;
	assign o_arready = arready_q;
	assign o_rvalid = rvalid_q;
	assign o_rdata = rdata_q;
	assign o_rresp = rresp_q;
	assign o_irq = irq_q;
endmodule : gpio_port_masked_access

// ### gpio_pkg.sv
// constants, register map and types shared by the gpio block
package gpio_pkg;
	localparam int NUM_PORTS = 4;
	localparam int PORT_W = 16;
	localparam int ADDR_W = 14;
	// pins present on each port, d down to a: 5 + 16 + 16 + 16 = 53 pins
	localparam logic [3:0][15:0] PIN_AVAIL = {16'h001f, 16'hffff, 16'hffff, 16'hffff};
	// per-port register offsets inside a 4 KB port region
	localparam logic [11:0] OFF_PIN = 12'h000;
	localparam logic [11:0] OFF_OUT = 12'h004;
	localparam logic [11:0] OFF_OUT_SET = 12'h008;
	localparam logic [11:0] OFF_OUT_CLR = 12'h00c;
	localparam logic [11:0] OFF_OE = 12'h010;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h014;
	localparam logic [11:0] OFF_RISE_EN = 12'h018;
	localparam logic [11:0] OFF_FALL_EN = 12'h01c;
	localparam logic [11:0] OFF_IRQ_STATUS = 12'h020;
	// masked windows: 256 words each, selected by offset bits 11:10
	localparam logic [1:0] WIN_LOW = 2'h1;
	localparam logic [1:0] WIN_HIGH = 2'h2;
	localparam logic [15:0] RST_REG = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {
		CH_IDLE = 1'b0,
		CH_RESP = 1'b1
	} ch_state_t;

	typedef struct packed {
		logic [15:0] out;
		logic [15:0] oe;
		logic [15:0] irq_mask;
		logic [15:0] rise_en;
		logic [15:0] fall_en;
		logic [15:0] status;
		logic [15:0] pin_prev;
	} port_regs_t;

	typedef struct packed {
		logic [1:0] port;
		logic [11:0] off;
	} reg_addr_t;

	function automatic reg_addr_t split_addr(input logic [13:0] a);
		reg_addr_t r;
		r.port = a[13:12];
		r.off = {a[11:2], 2'h0};
		return r;
	endfunction : split_addr

	// true for any offset that answers OKAY on the bus
	function automatic logic addr_ok(input logic [11:0] off);
		logic ok;
		ok = (off[11:10] == WIN_LOW) || (off[11:10] == WIN_HIGH);
		if (off <= OFF_IRQ_STATUS) begin
			ok = 1'b1;
		end
		return ok;
	endfunction : addr_ok

	// bit mask of a masked-window access, placed on its byte of the port
	function automatic logic [15:0] win_mask(input logic [11:0] off);
		logic [15:0] m;
		m = 16'h0000;
		if (off[11:10] == WIN_LOW) begin
			m = {8'h00, off[9:2]};
		end else if (off[11:10] == WIN_HIGH) begin
			m = {off[9:2], 8'h00};
		end
		return m;
	endfunction : win_mask
endpackage : gpio_pkg

// ### gpio_pad_model.sv
// pad model: each pin shows the block's output while enabled, else the outside level
`timescale 1ns/100ps
module gpio_pad_model (
	// block side
	input wire logic [3:0][15:0] i_out,
	input wire logic [3:0][15:0] i_oe,
	// outside world
	input wire logic [3:0][15:0] i_ext,
	output logic [3:0][15:0] o_pin
);
	assign o_pin = (i_out & i_oe) | (i_ext & ~i_oe);
endmodule : gpio_pad_model

// ### gpio_port_masked_access_sva.sv
// assertions on the gpio block ports
`timescale 1ns/100ps
module gpio_chk #(
	parameter int NUM_PORTS = 4,
	parameter int PORT_W = 16
) (
	// bus
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic [1:0] o_bresp,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire logic [31:0] o_rdata,
	// pads
	input wire logic [NUM_PORTS-1:0][PORT_W-1:0] o_port_output_value,
	input wire logic [NUM_PORTS-1:0][PORT_W-1:0] o_pin_oe
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	sequence s_wtake;
		i_awvalid && o_awready && i_wvalid && o_wready;
	endsequence
	sequence s_wfire;
		!o_awready ##1 o_bvalid;
	endsequence
	property p_wlat; s_wtake |=> s_wfire; endproperty
	a_wlat: assert property (p_wlat) else $error("write answer late");
	property p_bhold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rlat; i_arvalid && o_arready |=> o_rvalid; endproperty
	a_rlat: assert property (p_rlat) else $error("read answer late");
	property p_rhold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_rblk; o_rvalid |-> !o_arready; endproperty
	a_rblk: assert property (p_rblk) else $error("read taken while busy");
	property p_rhi; o_rvalid |-> o_rdata[31:16] == 16'h0000; endproperty
	a_rhi: assert property (p_rhi) else $error("read upper half not zero");
	property p_outchg; !$rose(o_bvalid) |-> $stable(o_port_output_value); endproperty
	a_outchg: assert property (p_outchg) else $error("output moved without write");
	property p_portd; o_port_output_value[3][15:5] == 11'h000 && o_pin_oe[3][15:5] == 11'h000; endproperty
	a_portd: assert property (p_portd) else $error("absent pin driven");
endmodule : gpio_chk
bind gpio_port_masked_access gpio_chk #(.NUM_PORTS(NUM_PORTS), .PORT_W(PORT_W)) u_gpio_chk (.i_clk(i_clk),
	.i_srst(i_srst), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
	.o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
	.o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_port_output_value(o_port_output_value),
	.o_pin_oe(o_pin_oe));

// ### testbench.sv
// self-checking bench for the gpio block
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
	logic [13:0] i_awaddr = 14'h0000, i_araddr = 14'h0000;
	logic [31:0] i_wdata = 32'h0000_0000, o_rdata, d;
	logic [3:0][15:0] ext = {4{16'h9a38}}, pin, outv, oe;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
	logic [1:0] o_bresp, o_rresp, rs;
	int n_mismatch = 0;
	int tests_run = 0;
	always #5 i_clk = ~i_clk;
	gpio_port_masked_access u_gpio_port_masked_access (.i_clk(i_clk), .i_srst(i_srst), .i_awvalid(i_awvalid),
		.o_awready(o_awready), .i_awaddr(i_awaddr), .i_awprot(3'h0), .i_wvalid(i_wvalid), .o_wready(o_wready),
		.i_wdata(i_wdata), .i_wstrb(4'hf), .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
		.i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr), .i_arprot(3'h0), .o_rvalid(o_rvalid),
		.i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp), .i_pin(pin), .o_port_output_value(outv),
		.o_pin_oe(oe), .o_irq(o_irq));
	gpio_pad_model u_gpio_pad_model (.i_out(outv), .i_oe(oe), .i_ext(ext), .o_pin(pin));
	task close_out;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out
	function automatic logic [13:0] ad(input logic [1:0] p, input logic [11:0] o);
		return {p, o};
	endfunction : ad
	task wr(input logic [13:0] a, input logic [15:0] v);
		int i;
		i = 0;
		@(posedge i_clk);
		i_awaddr <= a;
		i_wdata <= {16'h0000, v};
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		do begin
			@(posedge i_clk);
			i++;
			if (o_awready === 1'b1) i_awvalid <= 1'b0;
			if (o_wready === 1'b1) i_wvalid <= 1'b0;
			if (o_bvalid === 1'b1 && i_bready !== 1'b1) i_bready <= 1'b1;
		end while (!(i_bready === 1'b1 && o_bvalid === 1'b1) && i < 50);
		i_bready <= 1'b0;
		if (i >= 50) begin
			n_mismatch++;
			close_out();
		end
		`CHK("bresp", gpio_pkg::RESP_OKAY, o_bresp)
	endtask : wr
	task rd(input logic [13:0] a);
		int i;
		i = 0;
		@(posedge i_clk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		do begin
			@(posedge i_clk);
			i++;
			if (o_arready === 1'b1) i_arvalid <= 1'b0;
			if (o_rvalid === 1'b1 && i_rready !== 1'b1) i_rready <= 1'b1;
		end while (!(i_rready === 1'b1 && o_rvalid === 1'b1) && i < 50);
		i_rready <= 1'b0;
		d = o_rdata;
		rs = o_rresp;
		if (i >= 50) begin
			n_mismatch++;
			close_out();
		end
	endtask : rd
	task rc(input string n, input logic [13:0] a, input logic [15:0] e);
		rd(a);
		`CHK(n, {16'h0000, e}, d)
		`CHK("rresp", gpio_pkg::RESP_OKAY, rs)
	endtask : rc
	initial begin
		repeat (12) @(posedge i_clk);
		i_srst <= 1'b0;
		for (int p = 0; p < 4; p++) wr(ad(2'(p), gpio_pkg::OFF_OUT), 16'hffff ^ 16'(p));
		for (int p = 0; p < 4; p++) rc("port", ad(2'(p), gpio_pkg::OFF_OUT), (16'hffff ^ 16'(p)) & gpio_pkg::PIN_AVAIL[p]);
		$display("test ports done");
		wr(ad(2'h0, gpio_pkg::OFF_OUT_CLR), 16'h0ff0);
		rc("clr", ad(2'h0, gpio_pkg::OFF_OUT), 16'hf00f);
		wr(ad(2'h0, gpio_pkg::OFF_OUT_SET), 16'h0030);
		`CHK("set", 16'hf03f, outv[0])
		wr(ad(2'h0, gpio_pkg::OFF_OUT), 16'ha5c0);
		wr(ad(2'h0, {gpio_pkg::WIN_LOW, 8'hc3, 2'h0}), 16'h0003);
		`CHK("lowwin", 16'ha503, outv[0])
		wr(ad(2'h0, {gpio_pkg::WIN_HIGH, 8'h0f, 2'h0}), 16'h5a00);
		`CHK("highwin", 16'haa03, outv[0])
		`CHK("portb", 16'hfffe, outv[1])
		rc("lowrd", ad(2'h0, {gpio_pkg::WIN_LOW, 8'h0f, 2'h0}), 16'h0008);
		rc("highrd", ad(2'h0, {gpio_pkg::WIN_HIGH, 8'hf0, 2'h0}), 16'h9000);
		rd(ad(2'h0, 12'h024));
		`CHK("unmapped", gpio_pkg::RESP_SLVERR, rs)
		$display("test access done");
		wr(ad(2'h0, gpio_pkg::OFF_RISE_EN), 16'h0005);
		wr(ad(2'h0, gpio_pkg::OFF_FALL_EN), 16'h0006);
		wr(ad(2'h0, gpio_pkg::OFF_IRQ_MASK), 16'h0002);
		ext[0] <= 16'h9a3f;
		repeat (4) @(posedge i_clk);
		`CHK("masked", 1'b0, o_irq)
		wr(ad(2'h0, gpio_pkg::OFF_IRQ_MASK), 16'h0001);
		repeat (2) @(posedge i_clk);
		`CHK("irq", 1'b1, o_irq)
		rc("rise", ad(2'h0, gpio_pkg::OFF_IRQ_STATUS), 16'h0005);
		repeat (2) @(posedge i_clk);
		`CHK("irqclr", 1'b0, o_irq)
		ext[0] <= 16'h9a38;
		repeat (4) @(posedge i_clk);
		rc("fall", ad(2'h0, gpio_pkg::OFF_IRQ_STATUS), 16'h0006);
		rc("empty", ad(2'h0, gpio_pkg::OFF_IRQ_STATUS), 16'h0000);
		$display("test irq done");
		wr(ad(2'h0, gpio_pkg::OFF_OE), 16'h00ff);
		`CHK("oe", 16'h00ff, oe[0])
		rc("pinout", ad(2'h0, gpio_pkg::OFF_PIN), 16'h9a03);
		$display("test drive done");
		i_srst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_srst <= 1'b0;
		rc("reset", ad(2'h0, gpio_pkg::OFF_OUT), 16'h0000);
		rc("resetoe", ad(2'h0, gpio_pkg::OFF_OE), 16'h0000);
		`CHK("resetirq", 1'b0, o_irq)
		$display("test reset done");
		close_out();
	end
endmodule : testbench
